/* src/tec_pkg.sv */
// Shared constants and types for the translation error and bypass block
package tec_pkg;
	// Array sizes, address width and counter width
	localparam int PA_WIDTH      = 41;
	localparam int SMALL_ENTRIES = 16;
	localparam int BIG_ENTRIES   = 64;
	localparam int CNT_WIDTH     = 16;
	// Register map, byte offsets on the bus, and bus encodings
	localparam int               ADDR_BITS = 8;
	localparam logic [7:0]       OFS_CTRL  = 8'h00;
	localparam logic [7:0]       OFS_STAT  = 8'h04;
	localparam logic [7:0]       OFS_REPR  = 8'h08;
	localparam logic [7:0]       OFS_INVL  = 8'h0C;
	localparam int               CTRL_XLATE_BIT = 0;
	localparam int               STAT_FATAL_BIT = 0;
	localparam logic             CTRL_RESET     = 1'h0;
	localparam logic [1:0]       HTRANS_NONSEQ  = 2'h2;
	localparam logic             HRESP_OKAY     = 1'h0;

	// Entry attribute bits
	typedef struct packed {
		logic invertEndianAttr;
		logic privilegedAttr;
		logic writableAttr;
		logic nonfaultOnlyAttr;
		logic cacheableVirtualAttr;
		logic cacheablePhysicalAttr;
		logic sideEffectAttr;
	} tecAttr_type;

	// Attributes used while data translation is off
	localparam tecAttr_type BYPASS_ATTR = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1};

	typedef enum logic [3:0] {
		TRAP_NONE        = 4'h0,
		FETCH_XLATE_MISS = 4'h1,
		DATA_XLATE_MISS  = 4'h2,
		FETCH_ACC_ERR    = 4'h3,
		DATA_ACC_ERR     = 4'h4,
		VEC_PAGE_CROSS   = 4'h5,
		DATA_ACC_EXC     = 4'h6,
		PHYS_ADDR_WATCH  = 4'h7,
		WRITE_PROT       = 4'h8
	} tecTrap_type;

	// One lookup from the pipeline, with the array read-out
	typedef struct packed {
		logic                valid;
		logic                isFetch;
		logic                discard;
		logic                vecBasic;
		logic                isPrefetch;
		logic                isNonFault;
		logic                accessExc;
		logic                physWatch;
		logic                writeProt;
		logic                extMiss;
		logic [PA_WIDTH-1:0] va;
		logic [PA_WIDTH-1:0] smallPa;
		logic [PA_WIDTH-1:0] bigPa;
		tecAttr_type         smallAttr;
		tecAttr_type         bigAttr;
	} tecLookup_type;

	// Answer to the pipeline, one cycle after the lookup
	typedef struct packed {
		logic                valid;
		tecTrap_type         trap;
		logic [PA_WIDTH-1:0] pa;
		tecAttr_type         attr;
		logic                memReq;
		logic                prefetchDone;
	} tecResult_type;
endpackage

/* src/tec_xlate_error.sv */
// Translation error handling, bypass attributes and register slave
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

// Notes on behaviour
// - Small array multiple hit: access error
// - Big array multiple hit invalidates, unreported
// - Parity: invalidate big, repair small, silently
// - Traps in order; fixes even when speculative
// - Big parity only: invalidate, miss trap
// - Big multiple hit: invalidate all, miss
// - Both parity: repair small, invalidate big
// - Hit in both arrays: use big
// - Big parity plus multi: invalidate all involved
// - Small parity, big multi: repair, invalidate
// - Big parity, small multi: invalidate, error
// - Small parity and multi: repair, error
// - Two small copies; unrepairable error fatal
// - Basic part kills extended entry: page-cross
// - Invalidation leaves other exceptions unchanged
// - Multiple hit suppresses content-based exceptions
// - Physical address is 41 bits
// - No data cache control register
// - Bypass uses fixed attribute set
// - Bypass prefetch completes without memory access
// - Bypass nonfaulting load: data access exception
module tec_xlate_error #(
	parameter int SMALL = tec_pkg::SMALL_ENTRIES,
	parameter int BIG   = tec_pkg::BIG_ENTRIES
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire tec_pkg::tecLookup_type lookup,
	input  wire logic [SMALL-1:0]      smallHit,
	input  wire logic [SMALL-1:0]      smallPerr,
	input  wire logic [SMALL-1:0]      smallCopyBad,
	input  wire logic [BIG-1:0]        bigHit,
	input  wire logic [BIG-1:0]        bigPerr,
	input  wire logic [BIG-1:0]        extNeed,
	output tec_pkg::tecResult_type     result,
	output logic [BIG-1:0]             bigInvalidate,
	output logic [SMALL-1:0]           smallRepair,
	output logic                       fatalError,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp
);
	typedef struct packed {
		logic                           xlateEn;
		logic                           fatal;
		logic [tec_pkg::CNT_WIDTH-1:0]  repairs;
		logic [tec_pkg::CNT_WIDTH-1:0]  invals;
		logic                           dataSel;
		logic                           dataWrite;
		logic [tec_pkg::ADDR_BITS-1:0]  dataAddr;
		logic [31:0]                    rdata;
		tec_pkg::tecResult_type         res;
		logic [BIG-1:0]                 inval;
		logic [SMALL-1:0]               repair;
	} tecState_type;

	tecState_type s;
	tecState_type n;

	logic             bypass;
	logic             translated;
	logic             bigMulti;
	logic             smallMulti;
	logic             bigOne;
	logic             smallAny;
	logic             useBig;
	logic             useSmall;
	logic             accErr;
	logic             missTrap;
	logic             multiSeen;
	logic             pageCross;
	logic             fatalNow;
	logic [BIG-1:0]   bigGood;
	logic [BIG-1:0]   invalNow;
	logic [SMALL-1:0] repairNow;
	logic             addrOk;
	logic             wrCtrl;
	logic             wrStat;
	logic             wrRepr;
	logic             wrInvl;

	// Bypass covers data accesses only; fetches always translate
	assign bypass     = lookup.valid & ~lookup.isFetch & ~s.xlateEn;
	assign translated = lookup.valid & ~bypass;

	// More than one bit set: v & (v-1) is nonzero
	assign bigMulti   = |(bigHit & (bigHit - 1'b1));
	assign smallMulti = |(smallHit & (smallHit - 1'b1));
	assign bigGood    = bigHit & ~bigPerr;
	assign bigOne     = |bigGood & ~bigMulti;
	assign smallAny   = |smallHit;

	assign useBig   = translated & bigOne;
	assign useSmall = translated & ~bigOne & smallAny & ~smallMulti;
	assign accErr   = translated & ~bigOne & smallMulti;
	assign missTrap = translated & ~bigOne & ~smallAny;
	assign multiSeen = translated & (bigMulti | (smallMulti & ~bigOne));

	assign invalNow = translated ? (bigPerr | (bigMulti ? bigHit : '0)) : '0;
	assign repairNow = translated ? (smallPerr & ~smallCopyBad) : '0;
	assign fatalNow  = translated & |(smallPerr & smallCopyBad);

	assign pageCross = lookup.vecBasic & (|(invalNow & extNeed) | lookup.extMiss);

	// Register decode; only aligned word offsets are mapped
	assign addrOk = hsel & hready & htrans[1];
	assign wrCtrl = s.dataSel & s.dataWrite & (s.dataAddr == tec_pkg::OFS_CTRL);
	assign wrStat = s.dataSel & s.dataWrite & (s.dataAddr == tec_pkg::OFS_STAT);
	assign wrRepr = s.dataSel & s.dataWrite & (s.dataAddr == tec_pkg::OFS_REPR);
	assign wrInvl = s.dataSel & s.dataWrite & (s.dataAddr == tec_pkg::OFS_INVL);

	// Next state: registers, bus and lookup answer
	always_comb
	begin
		n = s;
		if (wrCtrl)
			n.xlateEn = hwdata[tec_pkg::CTRL_XLATE_BIT];
		// Set wins over a same-cycle clear
		n.fatal = (s.fatal & ~(wrStat & hwdata[tec_pkg::STAT_FATAL_BIT])) | fatalNow;
		if (wrRepr)
			n.repairs = '0;
		if (|repairNow)
			n.repairs = n.repairs + 1'b1;
		if (wrInvl)
			n.invals = '0;
		if (|invalNow)
			n.invals = n.invals + 1'b1;

		// fixes act even on discarded lookups
		n.inval  = invalNow;
		n.repair = repairNow;

		n.res.valid        = lookup.valid;
		n.res.trap         = tec_pkg::TRAP_NONE;
		n.res.memReq       = 1'b0;
		n.res.prefetchDone = 1'b0;
		n.res.pa   = useBig ? lookup.bigPa : (useSmall ? lookup.smallPa : lookup.va);
		n.res.attr = useBig ? lookup.bigAttr : lookup.smallAttr;
		if (bypass)
		begin
			n.res.attr = tec_pkg::BYPASS_ATTR;
			n.res.pa   = lookup.va;
			if (lookup.isNonFault & ~lookup.isPrefetch)
				n.res.trap = tec_pkg::DATA_ACC_EXC;
			else if (lookup.accessExc)
				n.res.trap = tec_pkg::DATA_ACC_EXC;
		end
		else if (accErr)
			n.res.trap = lookup.isFetch ? tec_pkg::FETCH_ACC_ERR : tec_pkg::DATA_ACC_ERR;
		else if (missTrap)
			n.res.trap = lookup.isFetch ? tec_pkg::FETCH_XLATE_MISS : tec_pkg::DATA_XLATE_MISS;
		else if (multiSeen)
			n.res.trap = tec_pkg::TRAP_NONE;
		else if (pageCross)
			n.res.trap = tec_pkg::VEC_PAGE_CROSS;
		else if (lookup.accessExc)
			n.res.trap = tec_pkg::DATA_ACC_EXC;
		else if (lookup.physWatch)
			n.res.trap = tec_pkg::PHYS_ADDR_WATCH;
		else if (lookup.writeProt)
			n.res.trap = tec_pkg::WRITE_PROT;
		// Squashed lookups never trap, so order stays with commit
		if (lookup.discard | ~lookup.valid)
			n.res.trap = tec_pkg::TRAP_NONE;
		n.res.prefetchDone = bypass & lookup.isPrefetch & ~lookup.discard;
		n.res.memReq = lookup.valid & ~lookup.discard & (n.res.trap == tec_pkg::TRAP_NONE)
			& ~(bypass & lookup.isPrefetch);

		// Capture address phase; read data built from updated values
		n.dataSel   = addrOk;
		n.dataWrite = hwrite;
		n.dataAddr  = haddr[tec_pkg::ADDR_BITS-1:0];
		n.rdata     = '0;
		if (addrOk & ~hwrite)
		begin
			unique case (haddr[tec_pkg::ADDR_BITS-1:0])
				tec_pkg::OFS_CTRL: n.rdata[tec_pkg::CTRL_XLATE_BIT] = n.xlateEn;
				tec_pkg::OFS_STAT: n.rdata[tec_pkg::STAT_FATAL_BIT] = n.fatal;
				tec_pkg::OFS_REPR: n.rdata[tec_pkg::CNT_WIDTH-1:0] = n.repairs;
				tec_pkg::OFS_INVL: n.rdata[tec_pkg::CNT_WIDTH-1:0] = n.invals;
				default:           n.rdata = '0;
			endcase
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s         <= '0;
			s.xlateEn <= tec_pkg::CTRL_RESET;
		end
		else
			s <= n;
	end

	// Outputs; slave never inserts wait states
	assign result        = s.res;
	assign bigInvalidate = s.inval;
	assign smallRepair   = s.repair;
	assign fatalError    = s.fatal;
	assign hreadyout     = 1'b1;
	assign hrdata        = s.rdata;
	assign hresp         = tec_pkg::HRESP_OKAY;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_translated;
		lookup.valid && !bypass;
	endsequence
	sequence s_bypassed;
		lookup.valid && bypass && !lookup.discard;
	endsequence

	a_small_multi_err: assert property (
		s_translated and (smallMulti && !bigOne && !lookup.discard) |=>
		(result.trap == tec_pkg::FETCH_ACC_ERR || result.trap == tec_pkg::DATA_ACC_ERR))
		else $error("small multiple hit without access error");

	a_big_multi_inval: assert property (
		s_translated and bigMulti |=> ((bigInvalidate & $past(bigHit)) == $past(bigHit)))
		else $error("big multiple hit entries not invalidated");

	a_small_repair: assert property (
		s_translated |=> smallRepair == ($past(smallPerr) & ~$past(smallCopyBad)))
		else $error("small entry repair mismatch");

	a_spec_inval: assert property (
		s_translated and (lookup.discard && |bigPerr) |=>
		(|bigInvalidate && result.trap == tec_pkg::TRAP_NONE))
		else $error("discarded lookup lost its invalidation or trapped");

	a_perr_miss: assert property (
		s_translated and (bigHit != '0 && bigGood == '0 && !smallAny && !lookup.discard) |=>
		(result.trap == tec_pkg::FETCH_XLATE_MISS || result.trap == tec_pkg::DATA_XLATE_MISS))
		else $error("big parity error without miss trap");

	a_both_hit_big: assert property (
		s_translated and (bigOne && smallAny) |=> result.pa == $past(lookup.bigPa))
		else $error("hit in both arrays did not use big entry");

	a_multi_suppress: assert property (
		s_translated and bigMulti |=> !(result.trap inside {tec_pkg::DATA_ACC_EXC,
		tec_pkg::PHYS_ADDR_WATCH, tec_pkg::WRITE_PROT, tec_pkg::VEC_PAGE_CROSS}))
		else $error("content exception raised on multiple hit");

	a_page_cross: assert property (
		s_translated and (lookup.vecBasic && |(invalNow & extNeed) && !multiSeen
		&& !missTrap && !lookup.discard) |=> result.trap == tec_pkg::VEC_PAGE_CROSS)
		else $error("lost extended entry without page cross trap");

	a_fatal_sticky: assert property (
		fatalNow |=> fatalError ##1
		(fatalError || $past(wrStat & hwdata[tec_pkg::STAT_FATAL_BIT])))
		else $error("unrepairable error not held fatal");

	a_bypass_attr: assert property (
		s_bypassed |=> result.attr == tec_pkg::BYPASS_ATTR && result.pa == $past(lookup.va))
		else $error("bypass attributes wrong");

	a_prefetch_nomem: assert property (
		s_bypassed and lookup.isPrefetch |=> result.prefetchDone && !result.memReq)
		else $error("bypass prefetch issued a memory access");

	a_nonfault_exc: assert property (
		s_bypassed and (lookup.isNonFault && !lookup.isPrefetch) |=>
		result.trap == tec_pkg::DATA_ACC_EXC)
		else $error("bypass nonfaulting load completed");

	a_fetch_side: assert property (
		s_translated and (lookup.isFetch && missTrap && !lookup.discard) |=>
		result.trap == tec_pkg::FETCH_XLATE_MISS)
		else $error("fetch miss reported on data side");

	a_big_multi_miss: assert property (
		s_translated and (bigMulti && !smallAny && !lookup.discard) |=>
		(result.trap == tec_pkg::FETCH_XLATE_MISS || result.trap == tec_pkg::DATA_XLATE_MISS))
		else $error("big multiple hit without miss trap");

	a_union_inval: assert property (
		s_translated and bigMulti |=>
		bigInvalidate == ($past(bigHit) | $past(bigPerr)))
		else $error("multiple hit and parity entries not all invalidated");

	a_perr_small_multi: assert property (
		s_translated and (|(bigHit & bigPerr) && !bigMulti && smallMulti
		&& !lookup.discard) |=> (|bigInvalidate
		&& (result.trap == tec_pkg::FETCH_ACC_ERR || result.trap == tec_pkg::DATA_ACC_ERR)))
		else $error("big parity with small multiple hit mishandled");

	a_exc_passthru: assert property (
		s_translated and (lookup.accessExc && !accErr && !missTrap && !multiSeen
		&& !pageCross && !lookup.discard) |=> result.trap == tec_pkg::DATA_ACC_EXC)
		else $error("other exception lost beside invalidation");
endmodule

/* verification/tec_pipe_model.sv */
// Pipeline-side model that presents lookups and array read-out
`timescale 1ns/1ps
module tec_pipe_model (
	input  wire logic                                clk,
	output tec_pkg::tecLookup_type                  lookup,
	output logic [tec_pkg::SMALL_ENTRIES-1:0]        smallHit,
	output logic [tec_pkg::SMALL_ENTRIES-1:0]        smallPerr,
	output logic [tec_pkg::SMALL_ENTRIES-1:0]        smallCopyBad,
	output logic [tec_pkg::BIG_ENTRIES-1:0]          bigHit,
	output logic [tec_pkg::BIG_ENTRIES-1:0]          bigPerr,
	output logic [tec_pkg::BIG_ENTRIES-1:0]          extNeed
);
	// Quiet pipeline at time zero
	initial
	begin
		lookup = '0;
		{smallHit, smallPerr, smallCopyBad, bigHit, bigPerr, extNeed} = '0;
	end

	// One lookup for one cycle; idle fields then change so stale values never match
	task automatic send(input tec_pkg::tecLookup_type l, input logic [15:0] sh, sp, sb,
		input logic [63:0] bh, bp, en);
		tec_pkg::tecLookup_type idle;
		idle = ~l;
		idle.valid = 1'h0;
		@(posedge clk);
		lookup <= l;
		{smallHit, smallPerr, smallCopyBad, bigHit, bigPerr, extNeed} <= {sh, sp, sb, bh, bp, en};
		@(posedge clk);
		lookup <= idle;
		{smallHit, smallPerr, smallCopyBad, bigHit, bigPerr, extNeed} <= '0;
	endtask
endmodule

/* verification/tec_xlate_error_tb.sv */
// Self-checking bench for the translation error and bypass block
`timescale 1ns/1ps
module tec_xlate_error_tb;
	localparam logic [15:0]         Z16 = 16'h0;
	localparam logic [15:0]         S3  = 16'h0008;
	localparam logic [15:0]         S34 = 16'h0018;
	localparam logic [63:0]         Z64 = 64'h0;
	localparam logic [63:0]         B5  = 64'h0000_0000_0000_0020;
	localparam logic [63:0]         B59 = 64'h0000_0000_0000_0220;
	localparam logic [40:0]         VA  = 41'h00_1234_5000;
	localparam logic [40:0]         SPA = 41'h01_0000_0000;
	localparam logic [40:0]         BPA = 41'h02_0000_0000;
	logic                           clk;
	logic                           rst;
	tec_pkg::tecLookup_type         lookup;
	tec_pkg::tecResult_type         result;
	logic [15:0]                    smallHit, smallPerr, smallCopyBad, smallRepair;
	logic [63:0]                    bigHit, bigPerr, extNeed, bigInvalidate;
	logic                           fatalError, hsel, hwrite, hreadyout, hresp;
	logic [31:0]                    haddr, hwdata, hrdata, rd;
	logic [1:0]                     htrans;
	int                             errors, compares;

	tec_xlate_error i_tec_xlate_error (.clk(clk), .rst(rst), .lookup(lookup),
		.smallHit(smallHit), .smallPerr(smallPerr), .smallCopyBad(smallCopyBad),
		.bigHit(bigHit), .bigPerr(bigPerr), .extNeed(extNeed), .result(result),
		.bigInvalidate(bigInvalidate), .smallRepair(smallRepair), .fatalError(fatalError),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp));

	tec_pipe_model i_tec_pipe_model (.clk(clk), .lookup(lookup), .smallHit(smallHit),
		.smallPerr(smallPerr), .smallCopyBad(smallCopyBad), .bigHit(bigHit),
		.bigPerr(bigPerr), .extNeed(extNeed));

	// Free-running core clock
	always #5 clk = ~clk;

	task automatic check(input logic [63:0] got, exp, input string what);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	// Single word transfer; zero wait is not assumed, hready is polled
	task automatic ahbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= {24'h00_0000, a};
		htrans <= tec_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd = hrdata;
		#1;
	endtask

	// Option bits: fetch, discard, vector basic, access exc, copy bad, prefetch, nonfault
	task automatic runCase(input logic [6:0] o, input logic [15:0] sh, sp,
		input logic [63:0] bh, bp, input tec_pkg::tecTrap_type t,
		input logic [63:0] inv, input logic [15:0] rep);
		tec_pkg::tecLookup_type l;
		l = '0;
		l.valid = 1'h1;
		{l.isNonFault, l.isPrefetch, l.accessExc, l.vecBasic, l.discard, l.isFetch} =
			{o[6:5], o[3:0]};
		l.va = VA;
		l.smallPa = SPA;
		l.bigPa = BPA;
		i_tec_pipe_model.send(l, sh, sp, o[4] ? sp : Z16, bh, bp, o[2] ? bh : Z64);
		#1;
		check(64'(result.trap), 64'(t), "trap");
		check(bigInvalidate, inv, "invalidate");
		// A copy-bad entry has no good copy, so no repair is expected
		check(64'(smallRepair), 64'(rep), "repair");
		// Every lookup answers; memory only for a clean, live, non-prefetch access
		check(64'({result.valid, result.memReq}),
			64'({1'h1, (t == tec_pkg::TRAP_NONE) & ~o[1] & ~o[5]}), "valid and request");
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, well beyond the roughly 80 cycles the tests need
	initial
	begin
		#100000;
		errors++;
		tally_and_finish;
	end

	// Main sequence: bypass first, then every error combination translated
	initial
	begin
		{clk, rst, hsel, hwrite} = 4'h4;
		{haddr, hwdata, rd, htrans} = '0;
		errors = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		#1;
		check(64'({result.valid, fatalError}), 64'h0, "reset outputs");
		ahbXfer(1'h0, tec_pkg::OFS_CTRL, 32'h0);
		check(64'(rd), 64'h0, "ctrl reset");
		runCase(7'h40, Z16, Z16, Z64, Z64, tec_pkg::DATA_ACC_EXC, Z64, Z16);
		check(64'(result.pa), 64'(VA), "bypass pa");
		check(64'(result.attr), 64'h11, "bypass attr");
		runCase(7'h20, Z16, Z16, Z64, Z64, tec_pkg::TRAP_NONE, Z64, Z16);
		check(64'({result.memReq, result.prefetchDone}), 64'h1, "prefetch");
		ahbXfer(1'h1, tec_pkg::OFS_CTRL, 32'h0000_0001);
		ahbXfer(1'h0, tec_pkg::OFS_CTRL, 32'h0);
		check(64'(rd), 64'h1, "ctrl readback");
		ahbXfer(1'h0, 8'h10, 32'h0);
		check(64'({hresp, rd}), 64'h0, "unmapped read");
		runCase(7'h01, Z16, Z16, B5, B5, tec_pkg::FETCH_XLATE_MISS, B5, Z16);
		runCase(7'h00, Z16, Z16, B5, B5, tec_pkg::DATA_XLATE_MISS, B5, Z16);
		runCase(7'h00, S3, S3, Z64, Z64, tec_pkg::TRAP_NONE, Z64, S3);
		check(64'(result.pa), 64'(SPA), "small translation used");
		runCase(7'h00, S3, S3, B5, B5, tec_pkg::TRAP_NONE, B5, S3);
		runCase(7'h01, Z16, Z16, B59, Z64, tec_pkg::FETCH_XLATE_MISS, B59, Z16);
		runCase(7'h00, Z16, Z16, B59, Z64, tec_pkg::DATA_XLATE_MISS, B59, Z16);
		runCase(7'h01, S34, Z16, Z64, Z64, tec_pkg::FETCH_ACC_ERR, Z64, Z16);
		runCase(7'h00, S34, Z16, Z64, Z64, tec_pkg::DATA_ACC_ERR, Z64, Z16);
		runCase(7'h00, S3, Z16, B5, Z64, tec_pkg::TRAP_NONE, Z64, Z16);
		check(64'(result.pa), 64'(BPA), "big translation used");
		runCase(7'h00, Z16, Z16, B59, 64'h0200, tec_pkg::DATA_XLATE_MISS, B59, Z16);
		runCase(7'h00, S3, S3, B59, Z64, tec_pkg::TRAP_NONE, B59, S3);
		runCase(7'h00, S34, Z16, B5, B5, tec_pkg::DATA_ACC_ERR, B5, Z16);
		runCase(7'h01, S34, S3, Z64, Z64, tec_pkg::FETCH_ACC_ERR, Z64, S3);
		runCase(7'h08, S3, Z16, B59, Z64, tec_pkg::TRAP_NONE, B59, Z16);
		runCase(7'h08, S3, Z16, B5, B5, tec_pkg::DATA_ACC_EXC, B5, Z16);
		runCase(7'h04, S3, Z16, B5, B5, tec_pkg::VEC_PAGE_CROSS, B5, Z16);
		runCase(7'h02, Z16, Z16, B5, B5, tec_pkg::TRAP_NONE, B5, Z16);
		runCase(7'h10, S3, S3, Z64, Z64, tec_pkg::TRAP_NONE, Z64, Z16);
		check(64'(fatalError), 64'h1, "fatal raised");
		ahbXfer(1'h0, tec_pkg::OFS_STAT, 32'h0);
		check(64'(rd), 64'h1, "fatal sticky");
		ahbXfer(1'h1, tec_pkg::OFS_STAT, 32'h0000_0001);
		check(64'(fatalError), 64'h0, "fatal cleared");
		// Event counters: four repairing lookups, twelve invalidating ones
		ahbXfer(1'h0, tec_pkg::OFS_REPR, 32'h0);
		check(64'(rd), 64'h4, "repair count");
		ahbXfer(1'h0, tec_pkg::OFS_INVL, 32'h0);
		check(64'(rd), 64'hC, "invalidate count");
		ahbXfer(1'h1, tec_pkg::OFS_INVL, 32'h0);
		ahbXfer(1'h0, tec_pkg::OFS_INVL, 32'h0);
		check(64'(rd), 64'h0, "invalidate count cleared");
		tally_and_finish;
	end
endmodule
